/* rtl/ecp_pwm_timer.sv */
// eight channel pwm timer with apb register access
`include "ecp_map.svh"
module ecp_pwm_timer #(
    parameter int NCH = 8
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // waveform pins
    output logic      [NCH-1:0]    pwmOut
);
    // ****************************************************************
    // register file
    // ****************************************************************
    logic [7:0]       chEnable;
    logic [7:0]       chPolarity;
    logic [7:0]       chCenter;
    logic [3:0]       pairJoin;
    logic [7:0]       period   [NCH];
    logic [7:0]       duty     [NCH];
    logic [7:0]       count    [NCH];
    logic [NCH-1:0]   countDown;
    ecp_pkg::ecp_apbreq_t req;

    // bundle of the apb request
    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

    // ****************************************************************
    // address decode
    // ****************************************************************
    // match of a full word address against one register offset
    function automatic logic addrHit(input logic [11:0] addr, input logic [11:0] off);
        logic hit;
        hit = (addr == off);
        return hit;
    endfunction

    // control register hits, shared by read and write paths
    wire        hitEnable   = addrHit(req.addr, `ECP_OFF_ENABLE);
    wire        hitPolarity = addrHit(req.addr, `ECP_OFF_POLARITY);
    wire        hitAlign    = addrHit(req.addr, `ECP_OFF_ALIGN);
    wire        hitJoin     = addrHit(req.addr, `ECP_OFF_JOIN);

    // bus phase qualifiers
    wire        access   = req.sel & req.enable;
    wire        wrStb    = access & req.write;

    // table region: period, duty and count words, eight of each
    wire        inTable  = (req.addr >= `ECP_OFF_PERIOD0) && (req.addr < 12'h080)
                           && (req.addr[1:0] == 2'h0);
    wire [2:0]  tblIdx   = req.addr[4:2];
    wire [1:0]  tblSel   = 2'(req.addr[6:5] - 2'h1);
    wire        hitPeriod = inTable && (tblSel == 2'h0);
    wire        hitDuty   = inTable && (tblSel == 2'h1);
    wire        hitCount  = inTable && (tblSel == 2'h2);

    // anything outside these answers with an error
    wire        isCtrl   = hitEnable | hitPolarity | hitAlign | hitJoin;
    wire        mapped   = isCtrl | inTable;

    // ****************************************************************
    // read path
    // ****************************************************************
    // read mux, unused upper bits read zero
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (1'b1)
            hitEnable:   rdMux = {24'h000000, chEnable};
            hitPolarity: rdMux = {24'h000000, chPolarity};
            hitAlign:    rdMux = {24'h000000, chCenter};
            hitJoin:     rdMux = {28'h0000000, pairJoin};
            hitPeriod:   rdMux = {24'h000000, period[tblIdx]};
            hitDuty:     rdMux = {24'h000000, duty[tblIdx]};
            hitCount:    rdMux = {24'h000000, count[tblIdx]};
            default:     rdMux = 32'h0000_0000;
        endcase
    end

    // apb answer: one access cycle, error on unmapped address
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= req.sel & ~req.enable;
            pslverr <= req.sel & ~req.enable & ~mapped;
            prdata  <= rdMux;
        end
    end

    // ****************************************************************
    // write path
    // ****************************************************************
    // writes are taken in the access cycle, when pready is high
    wire wrTake = wrStb & pready & ~pslverr;

    // channel enable bits
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chEnable <= `ECP_RST_BYTE;
        end else if (wrTake && hitEnable) begin
            chEnable <= req.wdata[7:0];
        end
    end

    // polarity bits, one means start high
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chPolarity <= `ECP_RST_BYTE;
        end else if (wrTake && hitPolarity) begin
            chPolarity <= req.wdata[7:0];
        end
    end

    // alignment bits, one means center aligned
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chCenter <= `ECP_RST_BYTE;
        end else if (wrTake && hitAlign) begin
            chCenter <= req.wdata[7:0];
        end
    end

    // pair join bits, one per adjacent pair
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pairJoin <= `ECP_RST_JOIN;
        end else if (wrTake && hitJoin) begin
            pairJoin <= req.wdata[3:0];
        end
    end

    // ****************************************************************
    // channels
    // ****************************************************************
    // per channel period and duty tables
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gCh
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    period[g] <= `ECP_RST_PERIOD;
                    duty[g]   <= `ECP_RST_BYTE;
                end else if (wrTake && inTable && tblIdx == 3'(g)) begin
                    if (hitPeriod) period[g] <= req.wdata[7:0];
                    if (hitDuty)   duty[g]   <= req.wdata[7:0];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // pair engines
    // ****************************************************************
    // one engine per pair; low channel (even) is lsb, high (odd) msb when joined
    generate
        for (g = 0; g < NCH / 2; g++) begin : gPair
            localparam int LO = 2 * g;
            localparam int HI = 2 * g + 1;
            wire        joined = pairJoin[g];
            wire [15:0] cntW   = {count[HI], count[LO]};
            wire [15:0] perW   = {period[HI], period[LO]};
            wire [15:0] dutyW  = {duty[HI], duty[LO]};
            logic [15:0] next_cntW;
            logic        next_downW;
            logic [7:0]  next_cnt  [2];
            logic [1:0]  next_down;
            logic [1:0]  next_out;
            ecp_pkg::ecp_chcfg_t cfgW;
            ecp_pkg::ecp_chcfg_t cfg [2];

            // joined channel takes its settings from the high channel
            assign cfgW   = '{enable: chEnable[HI], polarity: chPolarity[HI], center: chCenter[HI]};
            assign cfg[0] = '{enable: chEnable[LO], polarity: chPolarity[LO], center: chCenter[LO]};
            assign cfg[1] = cfgW;

            // ********************************************************
            // joined counter step
            // ********************************************************
            // 16-bit joined counter step
            always_comb begin
                next_cntW  = cntW;
                next_downW = countDown[HI];
                if (!cfgW.enable) begin
                    next_cntW  = 16'h0000;
                    next_downW = 1'b0;
                end else if (cfgW.center) begin
                    if (countDown[HI]) begin
                        next_cntW  = (cntW <= 16'h0001) ? 16'h0000 : 16'(cntW - 16'h0001);
                        next_downW = (cntW > 16'h0001);
                    end else begin
                        next_cntW  = (cntW + 16'h0001 >= perW) ? perW : 16'(cntW + 16'h0001);
                        next_downW = (cntW + 16'h0001 >= perW);
                    end
                end else begin
                    next_cntW  = (cntW + 16'h0001 >= perW) ? 16'h0000 : 16'(cntW + 16'h0001);
                    next_downW = 1'b0;
                end
            end

            // ********************************************************
            // independent counter steps
            // ********************************************************
            // 8-bit independent counter steps
            for (genvar k = 0; k < 2; k++) begin : gHalf
                wire [7:0] c = count[LO + k];
                wire [7:0] p = period[LO + k];
                always_comb begin
                    next_cnt[k]  = c;
                    next_down[k] = countDown[LO + k];
                    if (!cfg[k].enable) begin
                        next_cnt[k]  = 8'h00;
                        next_down[k] = 1'b0;
                    end else if (cfg[k].center) begin
                        if (countDown[LO + k]) begin
                            next_cnt[k]  = (c <= 8'h01) ? 8'h00 : 8'(c - 8'h01);
                            next_down[k] = (c > 8'h01);
                        end else begin
                            next_cnt[k]  = ({1'b0, c} + 9'h001 >= {1'b0, p}) ? p : 8'(c + 8'h01);
                            next_down[k] = ({1'b0, c} + 9'h001 >= {1'b0, p});
                        end
                    end else begin
                        next_cnt[k]  = ({1'b0, c} + 9'h001 >= {1'b0, p}) ? 8'h00 : 8'(c + 8'h01);
                        next_down[k] = 1'b0;
                    end
                end
            end

            // ********************************************************
            // output compare
            // ********************************************************
            // output: starting level until count reaches duty, then opposite
            always_comb begin
                next_out[0] = 1'b0;
                next_out[1] = 1'b0;
                if (joined) begin
                    next_out[1] = cfgW.enable &
                                  ((next_cntW < dutyW) ? cfgW.polarity : ~cfgW.polarity);
                end else begin
                    next_out[0] = cfg[0].enable &
                                  ((next_cnt[0] < duty[LO]) ? cfg[0].polarity
                                                             : ~cfg[0].polarity);
                    next_out[1] = cfg[1].enable &
                                  ((next_cnt[1] < duty[HI]) ? cfg[1].polarity
                                                             : ~cfg[1].polarity);
                end
            end

            // ********************************************************
            // pair registers
            // ********************************************************
            // counter registers; joined halves hold the two bytes of one count
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    count[LO]     <= 8'h00;
                    count[HI]     <= 8'h00;
                end else begin
                    count[LO]     <= joined ? next_cntW[7:0]  : next_cnt[0];
                    count[HI]     <= joined ? next_cntW[15:8] : next_cnt[1];
                end
            end

            // count direction of center aligned channels
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    countDown[LO] <= 1'b0;
                    countDown[HI] <= 1'b0;
                end else begin
                    countDown[LO] <= joined ? 1'b0 : next_down[0];
                    countDown[HI] <= joined ? next_downW : next_down[1];
                end
            end

            // waveform pin registers, low while disabled
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    pwmOut[LO]    <= 1'b0;
                    pwmOut[HI]    <= 1'b0;
                end else begin
                    pwmOut[LO]    <= next_out[0];
                    pwmOut[HI]    <= next_out[1];
                end
            end
        end
    endgenerate
endmodule

/* rtl/ecp_map.svh */
// register offsets and reset values of the pwm timer
`ifndef ECP_MAP_SVH
`define ECP_MAP_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define ECP_OFF_ENABLE   12'h000
`define ECP_OFF_POLARITY 12'h004
`define ECP_OFF_ALIGN    12'h008
`define ECP_OFF_JOIN     12'h00c
`define ECP_OFF_PERIOD0  12'h020
`define ECP_OFF_DUTY0    12'h040
`define ECP_OFF_COUNT0   12'h060

// ****************************************************************
// reset values
// ****************************************************************
`define ECP_RST_BYTE     8'h00
`define ECP_RST_JOIN     4'h0
`define ECP_RST_PERIOD   8'hff

`endif

/* rtl/ecp_pkg.sv */
// types of the eight channel pwm timer
package ecp_pkg;
    // per channel configuration bundle
    typedef struct packed {
        logic       enable;
        logic       polarity;
        logic       center;
    } ecp_chcfg_t;

    // apb request bundle
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } ecp_apbreq_t;
endpackage

/* verification/ecp_pwm_timer_properties.sv */
// checker of bus timing and pin rules of the pwm timer
`include "ecp_map.svh"
module ecp_pwm_timer_properties (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // apb slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // waveform pins
    input wire logic [7:0]  pwmOut
);
    // ********
    // shadow of enable and join, with four cycles of history
    // ********
    logic [7:0] enReg, en1, en2, en3;
    logic [3:0] jn, jn1, jn2, jn3;
    wire        wrDone   = psel & penable & pready & pwrite;
    wire  [7:0] offMask  = ~(enReg | en1 | en2 | en3);
    wire  [3:0] joinMask = jn & jn1 & jn2 & jn3;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {enReg, en1, en2, en3} <= '0;
            {jn, jn1, jn2, jn3}    <= '0;
        end else begin
            if (wrDone && paddr == `ECP_OFF_ENABLE) enReg <= pwdata[7:0];
            if (wrDone && paddr == `ECP_OFF_JOIN) jn <= pwdata[3:0];
            {en3, en2, en1} <= {en2, en1, enReg};
            {jn3, jn2, jn1} <= {jn2, jn1, jn};
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_ready_next; psel && !penable |=> pready && penable; endproperty
    a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_misalign; psel && !penable && paddr[1:0] != 2'h0 |=> pslverr; endproperty
    a_misalign: assert property (p_misalign) else $error("misaligned accepted");
    property p_hole; psel && !penable && paddr == 12'h010 |=> pslverr; endproperty
    a_hole: assert property (p_hole) else $error("unmapped accepted");
    property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_off_low; (pwmOut & offMask) == 8'h00; endproperty
    a_off_low: assert property (p_off_low) else $error("disabled pin high");
    property p_even_low; ({pwmOut[6], pwmOut[4], pwmOut[2], pwmOut[0]} & joinMask) == 4'h0;
    endproperty
    a_even_low: assert property (p_even_low) else $error("joined even pin high");
endmodule

/* verification/testbench.sv */
// self checking bench of the pwm timer
`include "ecp_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h0, seed = 32'hfece, prdata, rd, v;
    logic        pready, pslverr, er;
    logic [7:0]  pwmOut;
    int          err_total = 0, check_count = 0;
    always #10 core_clk = ~core_clk;
    ecp_pwm_timer dut_u (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
                         .prdata, .pready, .pslverr, .pwmOut);
    // ********
    // bench tasks
    // ********
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) err_total++;
    endtask
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // cycles at high level in one whole period
    function automatic int ones(input int p, input int d, input int pol, input int ctr);
        int lo = ctr ? (d == 0 ? 0 : d > p ? 2 * p : 2 * d - 1) : (d > p ? p : d);
        return pol ? lo : (ctr ? 2 * p : p) - lo;
    endfunction
    task automatic measure(input int ch, input int len, output int cnt);
        cnt = 0;
        repeat (2 * len + 4) @(posedge core_clk);
        repeat (len) begin
            @(posedge core_clk);
            cnt += (pwmOut[ch] === 1'b1);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        give_verdict();
    end
    // main sequence
    initial begin
        int c, p, d, n, ct;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        for (c = 0; c < 4; c++) begin
            apb(1'b0, 12'(4 * c), 32'h0);
            check(rd, 32'h0);
        end
        for (c = 0; c < 8; c++) begin
            apb(1'b0, `ECP_OFF_PERIOD0 + 12'(4 * c), 32'h0);
            check(rd, 32'hff);
            apb(1'b0, `ECP_OFF_COUNT0 + 12'(4 * c), 32'h0);
            check(rd, 32'h0);
            v = xs();
            apb(1'b1, `ECP_OFF_DUTY0 + 12'(4 * c), v);
            apb(1'b0, `ECP_OFF_DUTY0 + 12'(4 * c), 32'h0);
            check(rd, {24'h0, v[7:0]});
        end
        apb(1'b1, 12'h010, xs());
        check(32'(er), 32'h1);
        check(rd, 32'h0);
        apb(1'b0, 12'h001, 32'h0);
        check(32'(er), 32'h1);
        check(rd, 32'h0);
        for (c = 0; c < 16; c++) begin
            ct = c / 8;
            p = 2 + int'(xs() % 8);
            d = (c % 4 == 0) ? 0 : (c % 4 == 1) ? p + 1 : 1 + int'(xs() % (p - 1));
            v = xs();
            apb(1'b1, `ECP_OFF_PERIOD0 + 12'(4 * (c % 8)), 32'(p));
            apb(1'b1, `ECP_OFF_DUTY0 + 12'(4 * (c % 8)), 32'(d));
            apb(1'b1, `ECP_OFF_POLARITY, v);
            apb(1'b1, `ECP_OFF_ALIGN, ct ? 32'hff : 32'h0);
            apb(1'b1, `ECP_OFF_ENABLE, 32'h1 << (c % 8));
            measure(c % 8, ct ? 2 * p : p, n);
            check(n, ones(p, d, v[c % 8], ct));
        end
        apb(1'b1, `ECP_OFF_ALIGN, 32'h0);
        apb(1'b1, `ECP_OFF_JOIN, 32'h2);
        apb(1'b1, `ECP_OFF_PERIOD0 + 12'hc, 32'h1);
        apb(1'b1, `ECP_OFF_PERIOD0 + 12'h8, 32'h5);
        apb(1'b1, `ECP_OFF_DUTY0 + 12'hc, 32'h0);
        apb(1'b1, `ECP_OFF_DUTY0 + 12'h8, 32'h80);
        apb(1'b1, `ECP_OFF_POLARITY, 32'h08);
        apb(1'b1, `ECP_OFF_ENABLE, 32'h0c);
        measure(3, 261, n);
        check(n, ones(261, 128, 1, 0));
        apb(1'b1, `ECP_OFF_JOIN, 32'hf);
        apb(1'b1, `ECP_OFF_ENABLE, 32'hff);
        repeat (20) @(posedge core_clk);
        give_verdict();
    end
endmodule
bind ecp_pwm_timer ecp_pwm_timer_properties chk_u (.core_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pwmOut);
